/* logic/flagread_cmd.sv */
// Protection flag readback command handler with register port and interrupt.
// Assumes byte streams come from logic on CLK, not from pins.
//
// Behaviour
// - Wait for start byte 01h; drop all other bytes while idle.
// - Missing end byte 03h at its position gives a packet error reply.
// - Check byte not matching the computed sum gives a checksum error reply.
// - Length wrong for the format or for this command gives packet error.
// - After any error, do nothing else and return to waiting.
// - Lifecycle state not permitting the command gives acceptance error.
// - Authentication level one or zero gives a secure error.
// - Report only the highest priority fault in the fixed order.
// - Error reply is 81h, 00h, 0Ah, CBh, status, detail, address, sum, 03h.
// - Detail and address words always carry the unused code value.
// - Success reply is 81h, 00h, 13h, 4Bh, 18 flag bytes, sum, 03h.
// - A flag reads 1 when unprotected and 0 when protected.
// - Flag bytes go out lowest storage address first.
// - Bits 7 and 6 of the final flag byte always read 11b.
// - After the flag reply, change nothing and wait for next request.
//
// Design decisions made here: the register addresses and the plain strobed port.
`include "flagread_regs.svh"

module flagread_cmd
	import flagread_pkg::*;
#(
	parameter logic [15:0] MAX_LEN = 16'h0400, // Longest legal request body
	parameter logic [7:0]  STS_PKT = 8'hE1,    // Packet error code
	parameter logic [7:0]  STS_SUM = 8'hE2,    // Checksum error code
	parameter logic [7:0]  STS_ACC = 8'hE3,    // Acceptance error code
	parameter logic [7:0]  STS_SEC = 8'hE4     // Secure error code
)
(
	input  wire logic                  CLK,        // 40 MHz clock
	input  wire logic                  ARST_N,     // Async reset, active low
	input  wire logic [7:0]            RX_DATA,    // Received byte
	input  wire logic                  RX_VALID,   // Received byte strobe
	output logic [7:0]                 TX_DATA,    // Reply byte
	output logic                       TX_VALID,   // Reply byte valid
	input  wire logic                  TX_READY,   // Transport takes byte
	input  wire logic                  LC_PERMIT,  // Lifecycle allows readback
	input  wire logic [1:0]            AUTH_LEVEL, // Current auth level
	input  wire logic [`FLAG_BITS-1:0] FLAG_DATA,  // Stored protection flags
	input  wire logic [3:0]            REG_ADDR,   // Register byte address
	input  wire logic [31:0]           REG_WDATA,  // Register write data
	input  wire logic                  REG_WR,     // Register write strobe
	input  wire logic                  REG_RD,     // Register read strobe
	output logic [31:0]                REG_RDATA,  // Read data, next cycle
	output logic                       IRQ         // Level interrupt
);

	// ==========================================================
	// Elaboration checks
	if (MAX_LEN == 16'h0000)
	begin : g_bad_len
		$error("MAX_LEN must be at least one");
	end

	core_t      s;
	core_t      n;
	reply_req_t req;
	logic [7:0] gbyte;
	logic       glast;
	logic       gsummed;
	logic       rx_ok;
	logic       ours;
	logic       auth_low;
	logic       at_end;
	logic [4:0] ev;

	// Filler word of error replies, as a named constant so checks can slice it
	localparam logic [31:0] UW = `UNUSED_WORD;

	// ==========================================================
	// Reply byte generator
	assign req.is_err = s.is_err;
	assign req.sts    = s.sts;
	assign req.idx    = s.idx;
	assign req.sum    = 8'h00 - s.tsum;

	reply_byte_gen u_gen
	(
		.req     (req),
		.flags   (FLAG_DATA),
		.rbyte   (gbyte),
		.rlast   (glast),
		.rsummed (gsummed)
	);

	// ==========================================================
	// Decode helpers
	// Disabling the handler drops received bytes and holds the parse state where it is
	assign rx_ok    = RX_VALID && s.en;
	// Another opcode belongs to another handler, so it gets no reply
	assign ours     = (s.len != 16'h0000) && (s.opc == `OPC_FLAGS);
	assign auth_low = (AUTH_LEVEL == `AUTH_L0) || (AUTH_LEVEL == `AUTH_L1);
	assign at_end   = (s.st == ST_END) && rx_ok && ours;

	// ==========================================================
	// Next state
	always_comb
	begin
		n       = s;
		ev      = 5'h00;
		n.rdata = 32'h0000_0000;
		case (s.st)
			ST_IDLE:
			begin
				// Bytes arriving during a reply never reach here; ST_SEND drops them
				if (rx_ok && RX_DATA == `CMD_START)
					n.st = ST_LENH;
			end
			ST_LENH:
			begin
				if (rx_ok)
				begin
					n.len[15:8] = RX_DATA;
					n.rsum      = RX_DATA;
					n.st        = ST_LENL;
				end
			end
			ST_LENL:
			begin
				if (rx_ok)
				begin
					n.len[7:0] = RX_DATA;
					n.rsum     = s.rsum + RX_DATA;
					n.cnt      = 16'h0000;
					n.opc      = 8'h00;
					n.st       = ({s.len[15:8], RX_DATA} == 16'h0000) ? ST_SUM : ST_BODY;
				end
			end
			ST_BODY:
			begin
				// Long bodies are counted through so the end byte is found
				if (rx_ok)
				begin
					if (s.cnt == 16'h0000)
						n.opc = RX_DATA;
					n.rsum = s.rsum + RX_DATA;
					n.cnt  = s.cnt + 16'h0001;
					if (s.cnt + 16'h0001 == s.len)
						n.st = ST_SUM;
				end
			end
			ST_SUM:
			begin
				if (rx_ok)
				begin
					n.rsum = s.rsum + RX_DATA;
					n.st   = ST_END;
				end
			end
			ST_END:
			begin
				if (rx_ok)
				begin
					n.st     = ours ? ST_SEND : ST_IDLE;
					n.idx    = 5'h00;
					n.tsum   = 8'h00;
					n.txv    = 1'b0;
					n.is_err = 1'b1;
					// Fault priority, first match wins
					if (RX_DATA != `END_BYTE)
					begin
						n.sts = STS_PKT;
						ev[`IRQ_PKT] = ours;
					end
					else if (s.rsum != 8'h00)
					begin
						n.sts = STS_SUM;
						ev[`IRQ_SUM] = ours;
					end
					else if (s.len > MAX_LEN || s.len != `LEN_CMD)
					begin
						n.sts = STS_PKT;
						ev[`IRQ_PKT] = ours;
					end
					else if (!LC_PERMIT)
					begin
						n.sts = STS_ACC;
						ev[`IRQ_ACC] = ours;
					end
					else if (auth_low)
					begin
						n.sts = STS_SEC;
						ev[`IRQ_SEC] = ours;
					end
					else
					begin
						n.is_err = 1'b0;
						n.sts    = 8'h00;
						ev[`IRQ_OK] = ours;
					end
				end
			end
			ST_SEND:
			begin
				// Next byte loads when the slot is empty or being taken
				if (!s.txv || TX_READY)
				begin
					if (s.txv && s.last)
					begin
						n.txv = 1'b0;
						n.st  = ST_IDLE;
					end
					else
					begin
						n.txv  = 1'b1;
						n.txd  = gbyte;
						n.last = glast;
						n.idx  = s.idx + 5'h01;
						if (gsummed)
							n.tsum = s.tsum + gbyte;
					end
				end
			end
			default:
			begin
				n.st  = ST_IDLE;
				n.txv = 1'b0;
			end
		endcase

		// Register writes; a new event wins over its clear
		n.ists = s.ists | ev;
		if (REG_WR)
		begin
			case (REG_ADDR)
				`REG_IRQ_STAT: n.ists = (s.ists & ~REG_WDATA[4:0]) | ev;
				`REG_IRQ_MASK: n.imask = REG_WDATA[4:0];
				`REG_CTRL:     n.en = REG_WDATA[0];
				default:       n.en = s.en;
			endcase
		end

		// Register reads, answered in the next cycle
		if (REG_RD)
		begin
			case (REG_ADDR)
				`REG_IRQ_STAT: n.rdata = {27'h0000000, s.ists};
				`REG_IRQ_MASK: n.rdata = {27'h0000000, s.imask};
				`REG_CTRL:     n.rdata = {31'h00000000, s.en};
				`REG_STAT:     n.rdata = {16'h0000, s.sts, 4'h0, s.is_err, s.st};
				default:       n.rdata = 32'h0000_0000;
			endcase
		end

		n.irq = |(n.ists & n.imask);
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			s       <= '0;
			s.st    <= ST_IDLE;
			s.imask <= `MASK_RST;
			s.en    <= `CTRL_RST;
		end
		else
			s <= n;
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign TX_DATA   = s.txd;
	assign TX_VALID  = s.txv;
	assign REG_RDATA = s.rdata;
	assign IRQ       = s.irq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	chk_start_wait: assert property (
		s.st == ST_IDLE && rx_ok && RX_DATA != `CMD_START |=> s.st == ST_IDLE)
		else $error("non-start byte left idle");

	chk_end_fault: assert property (
		at_end && RX_DATA != `END_BYTE |=> s.is_err && s.sts == STS_PKT)
		else $error("missing end byte not reported");

	chk_fault_order: assert property (
		at_end && RX_DATA != `END_BYTE && s.rsum != 8'h00 |=> s.sts != STS_SUM)
		else $error("checksum outranked end byte fault");

	chk_sum_fault: assert property (
		at_end && RX_DATA == `END_BYTE && s.rsum != 8'h00 |=> s.sts == STS_SUM)
		else $error("checksum fault not reported");

	chk_len_fault: assert property (
		at_end && RX_DATA == `END_BYTE && s.rsum == 8'h00 && s.len != `LEN_CMD
		|=> s.is_err && s.sts == STS_PKT)
		else $error("length fault not reported");

	chk_accept_fault: assert property (
		at_end && RX_DATA == `END_BYTE && s.rsum == 8'h00
		&& s.len == `LEN_CMD && !LC_PERMIT |=> s.sts == STS_ACC)
		else $error("lifecycle refusal not reported");

	chk_secure_fault: assert property (
		at_end && RX_DATA == `END_BYTE && s.rsum == 8'h00
		&& s.len == `LEN_CMD && LC_PERMIT && auth_low |=> s.sts == STS_SEC)
		else $error("auth refusal not reported");

	chk_reply_head: assert property (
		s.st == ST_SEND && s.txv && s.idx == 5'h01
		|-> s.txd == `RPL_START ##0 !s.last)
		else $error("reply does not open with start byte");

	chk_unused_word: assert property (
		s.st == ST_SEND && s.txv && s.is_err && (s.idx == 5'h06 || s.idx == 5'h0A)
		|-> s.txd == UW[31:24])
		else $error("detail or address word wrong");

	chk_first_flag: assert property (
		s.st == ST_SEND && s.txv && !s.is_err && s.idx == 5'h05
		|-> s.txd == FLAG_DATA[7:0])
		else $error("first flag byte is not lowest address");

	chk_key_hidden: assert property (
		s.st == ST_SEND && s.txv && !s.is_err && s.idx == 5'h16
		|-> s.txd[7:6] == 2'b11)
		else $error("key hash flags exposed");

	chk_reply_done: assert property (
		s.st == ST_SEND && s.txv && s.last && TX_READY
		|=> s.st == ST_IDLE && !s.txv)
		else $error("handler did not return to idle");

endmodule : flagread_cmd

/* logic/flagread_pkg.sv */
// Types shared by the readback handler and its reply byte generator.
// Assumes the constants header is on the include path.
`include "flagread_regs.svh"

package flagread_pkg;

	// ==========================================================
	// Handler states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_LENH = 3'b001,
		ST_LENL = 3'b010,
		ST_BODY = 3'b011,
		ST_SUM  = 3'b100,
		ST_END  = 3'b101,
		ST_SEND = 3'b110
	} state_t;

	// Request to the reply byte generator
	typedef struct packed
	{
		logic       is_err;
		logic [7:0] sts;
		logic [4:0] idx;
		logic [7:0] sum;
	} reply_req_t;

	// Whole state of the handler
	typedef struct packed
	{
		state_t      st;
		logic [15:0] len;
		logic [15:0] cnt;
		logic [7:0]  rsum;
		logic [7:0]  opc;
		logic        is_err;
		logic [7:0]  sts;
		logic [4:0]  idx;
		logic [7:0]  tsum;
		logic [7:0]  txd;
		logic        txv;
		logic        last;
		logic [4:0]  ists;
		logic [4:0]  imask;
		logic        en;
		logic [31:0] rdata;
		logic        irq;
	} core_t;

endpackage : flagread_pkg

/* logic/flagread_regs.svh */
// Constants for the protection flag readback command handler.
// Assumes it is included by bare name from the package and every module except host_model.
`ifndef FLAGREAD_REGS_SVH
`define FLAGREAD_REGS_SVH

// ==========================================================
// Packet bytes
`define CMD_START   8'h01
`define END_BYTE    8'h03
`define OPC_FLAGS   8'h4B
`define RPL_START   8'h81
`define RPL_ERR     8'hCB
`define LEN_HI_RPL  8'h00
`define LEN_ERR     8'h0A
`define LEN_OK      8'h13
`define LEN_CMD     16'h0001
`define UNUSED_WORD 32'h0FFFFFFF
`define HIDE_MASK   8'hC0

// ==========================================================
// Reply geometry
`define FLAG_BYTES  18
`define FLAG_BITS   144
`define N_ERR       5'h0F
`define N_OK        5'h18

// ==========================================================
// Authentication levels that are refused
`define AUTH_L0     2'h0
`define AUTH_L1     2'h1

// ==========================================================
// Register offsets, reset values, interrupt bit positions
`define REG_IRQ_STAT 4'h0
`define REG_IRQ_MASK 4'h4
`define REG_CTRL     4'h8
`define REG_STAT     4'hC
`define CTRL_RST     1'b1
`define MASK_RST     5'h00
`define IRQ_OK       0
`define IRQ_PKT      1
`define IRQ_SUM      2
`define IRQ_ACC      3
`define IRQ_SEC      4

`endif

/* logic/reply_byte_gen.sv */
// Reply byte generator: picks the byte at a given reply position.
// Assumes the caller steps the index from zero and supplies the sum byte.
`include "flagread_regs.svh"

module reply_byte_gen
	import flagread_pkg::*;
(
	input  wire reply_req_t          req,     // Reply kind, index, status, sum
	input  wire logic [`FLAG_BITS-1:0] flags, // Flag area, lowest address low
	output logic [7:0]               rbyte,   // Byte at this position
	output logic                     rlast,   // Position holds the end byte
	output logic                     rsummed  // Byte counts toward the sum
);

	localparam logic [31:0] UW = `UNUSED_WORD;

	logic [7:0] fbyte [0:`FLAG_BYTES-1];
	logic [4:0] n_bytes;
	logic [1:0] wsel;

	// ==========================================================
	// Flag bytes, top byte with the key hash bits hidden
	genvar i;
	for (i = 0; i < `FLAG_BYTES; i++)
	begin : g_flag
		if (i == `FLAG_BYTES - 1)
		begin : g_top
			assign fbyte[i] = flags[8*i +: 8] | `HIDE_MASK;
		end
		else
		begin : g_low
			assign fbyte[i] = flags[8*i +: 8];
		end
	end

	assign n_bytes = req.is_err ? `N_ERR : `N_OK;
	assign wsel    = 2'(req.idx - 5'h05);

	// ==========================================================
	// Position decode; word bytes go out most significant first
	always_comb
	begin
		rbyte   = 8'h00;
		rlast   = (req.idx == n_bytes - 5'h01);
		rsummed = (req.idx >= 5'h01) && (req.idx <= n_bytes - 5'h03);
		if (req.idx == 5'h00)
			rbyte = `RPL_START;
		else if (req.idx == 5'h01)
			rbyte = `LEN_HI_RPL;
		else if (req.idx == 5'h02)
			rbyte = req.is_err ? `LEN_ERR : `LEN_OK;
		else if (req.idx == 5'h03)
			rbyte = req.is_err ? `RPL_ERR : `OPC_FLAGS;
		else if (req.idx == n_bytes - 5'h02)
			rbyte = req.sum;
		else if (rlast)
			rbyte = `END_BYTE;
		else if (!req.is_err)
			rbyte = fbyte[req.idx - 5'h04];
		else if (req.idx == 5'h04)
			rbyte = req.sts;
		else
			rbyte = UW[{~wsel, 3'b000} +: 8];
	end

endmodule : reply_byte_gen

/* sim/host_model.sv */
// Host tool model: frames and sums requests, takes reply bytes.
// Assumes one clock shared with the handler; the bench calls its tasks.
module host_model
(
	input  wire logic       CLK,      // Bench clock
	output logic [7:0]      rx_data,  // Byte to the handler
	output logic            rx_valid, // Byte strobe
	input  wire logic [7:0] tx_data,  // Reply byte
	input  wire logic       tx_valid, // Reply byte offered
	output logic            tx_ready, // Reply byte taken
	input  wire logic       slow      // Stall the reply at random
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] got[$];
	logic [7:0] lfsr = 8'hA5;

	// Idle request line at time zero
	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end

	// ==========================================================
	// Reply side: a slow host stalls on a pseudo-random pattern
	always @(posedge CLK)
	begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		tx_ready <= !slow || lfsr[0];
	end

	// ==========================================================
	// Request side: bytes back to back; released line shows no stale byte
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i])
		begin
			rx_data <= q[i];
			rx_valid <= 1'b1;
			@(posedge CLK);
		end
		rx_data <= ~q[q.size() - 1];
		rx_valid <= 1'b0;
	endtask : send

	// Junk bytes, then a framed request; body padding is zero bytes
	task automatic request(input logic [7:0] length_low_byte, input logic [7:0] endb,
		input logic [3:0] noise, input logic sumbad, input logic [7:0] junk);
		logic [7:0] q[$];
		logic [7:0] s;
		q = {};
		repeat (noise)
			q.push_back(junk);
		s = 8'h00 - length_low_byte - 8'h4B;
		q = {q, 8'h01, 8'h00, length_low_byte, 8'h4B};
		repeat (length_low_byte - 8'h01)
			q.push_back(8'h00);
		q = {q, s + 8'(sumbad), endb};
		send(q);
	endtask : request
endmodule : host_model

/* sim/tb.sv */
// Bench for the flag readback handler: table of requests, reply model.
// Assumes the package and constants header are compiled first.
`include "flagread_regs.svh"

module tb
	import flagread_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  clk;
	logic                  arst_n;
	logic [7:0]            rx_data;
	logic                  rx_valid;
	logic [7:0]            tx_data;
	logic                  tx_valid;
	logic                  tx_ready;
	logic                  lc_permit;
	logic [1:0]            auth_level;
	logic [`FLAG_BITS-1:0] flag_data;
	logic [3:0]            reg_addr;
	logic [31:0]           reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [31:0]           reg_rdata;
	logic                  irq;
	logic                  slow;
	logic [7:0]            exp[$];
	int                    n_errors = 0;
	int                    samples_checked = 0;
	int                    seed = 32'hc92bfa9f;
	// {length low, end byte, junk, bad sum, lifecycle, auth (F random ok), status}
	logic [39:0]           tbl [12] = '{40'h01_03_3_0_1_F_00, 40'h01_03_0_0_1_F_00,
		40'h01_04_0_0_1_F_21, 40'h01_03_0_1_1_F_22, 40'h01_04_0_1_1_F_21,
		40'h02_03_0_0_1_F_21, 40'h02_03_0_0_0_0_21, 40'h01_03_0_0_0_F_23,
		40'h01_03_0_0_0_0_23, 40'h01_03_0_0_1_0_24, 40'h01_03_0_0_1_1_24,
		40'h01_03_2_0_1_F_00};

	flagread_cmd #(.STS_PKT(8'h21), .STS_SUM(8'h22),
		.STS_ACC(8'h23), .STS_SEC(8'h24)) i_dut (.CLK(clk), .ARST_N(arst_n),
		.RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data),
		.TX_VALID(tx_valid), .TX_READY(tx_ready), .LC_PERMIT(lc_permit),
		.AUTH_LEVEL(auth_level), .FLAG_DATA(flag_data), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .IRQ(irq));

	host_model i_host (.CLK(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

	// ==========================================================
	// Clock and checking tasks
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			n_errors++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask : check

	task automatic print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		// Random upper bits must be ignored by every register
		reg_wdata <= d | {27'($random(seed)), 5'h00};
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : reg_write

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, input logic [31:0] want);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, want);
		@(posedge clk);
	endtask : reg_read

	// ==========================================================
	// One request: model the reply from the inputs, then compare it whole
	task automatic run(input logic [39:0] t);
		logic [159:0] rnd;
		int s;
		int n;
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
		flag_data <= rnd[143:0];
		slow <= rnd[159];
		lc_permit <= t[12];
		auth_level <= (t[11:8] == 4'hF) ? {1'b1, rnd[150]} : t[9:8];
		@(posedge clk);
		exp = {8'h81, 8'h00};
		if (t[7:0] == 8'h00)
		begin
			exp = {exp, 8'h13, 8'h4B};
			for (int i = 0; i < 18; i++)
				exp.push_back(flag_data[8*i +: 8] | ((i == 17) ? 8'hC0 : 8'h00));
		end
		else
			exp = {exp, 8'h0A, 8'hCB, t[7:0], 8'h0F, 8'hFF, 8'hFF, 8'hFF,
				8'h0F, 8'hFF, 8'hFF, 8'hFF};
		s = 0;
		for (int i = 1; i < exp.size(); i++)
			s += exp[i];
		exp = {exp, 8'(-s), 8'h03};
		i_host.request(t[39:32], t[31:24], t[23:20], t[16], {1'b1, rnd[158:152]});
		n = 0;
		while (i_host.got.size() < exp.size() && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		// Extra idle cycles expose any stray byte after the reply
		repeat (8) @(posedge clk);
		check(i_host.got.size(), exp.size());
		foreach (exp[i])
			check(i_host.got[i], exp[i]);
		i_host.got.delete();
		$display("test %h done", t);
	endtask : run

	// ==========================================================
	// Main sequence: reset, request table, interrupt registers
	initial
	begin
		arst_n = 1'b0;
		lc_permit = 1'b1;
		auth_level = 2'h2;
		flag_data = '0;
		slow = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		foreach (tbl[k])
			run(tbl[k]);
		check(irq, 1'b0);
		reg_read(4'h8, 32'h1);
		reg_read(4'h4, 32'h0);
		reg_read(4'h0, 32'h1F);
		reg_read(4'h2, 32'h0);
		reg_write(4'h4, 32'h4);
		@(posedge clk);
		check(irq, 1'b1);
		// Clearing masked bits must leave the interrupt up
		reg_write(4'h0, 32'h1B);
		@(posedge clk);
		check(irq, 1'b1);
		reg_write(4'h0, 32'h4);
		@(posedge clk);
		check(irq, 1'b0);
		// A disabled handler ignores a whole valid request and raises no event
		reg_write(4'h8, 32'h0);
		i_host.request(8'h01, 8'h03, 4'h1, 1'b0, {1'b1, 7'($random(seed))});
		repeat (40) @(posedge clk);
		check(i_host.got.size(), 0);
		reg_read(4'h8, 32'h0);
		reg_write(4'h8, 32'h1);
		reg_read(4'h0, 32'h0);
		$display("test registers done");
		print_verdict;
	end

	// Watchdog: the whole run needs well under 20000 cycles
	initial
	begin
		#(20000 * 25);
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		print_verdict;
	end
endmodule : tb
